// ==== core/sbr_pkg.sv ====
// constants, field layout and types of the serial-bus phy base register file
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package sbr_pkg;

	// -----------------------------------------------------------------------
	// register addresses
	// -----------------------------------------------------------------------
	localparam logic [3:0] SBR_OFS_NODE_IDENTITY  = 4'h0; // node_identity_status
	localparam logic [3:0] SBR_OFS_RESET_GAP      = 4'h1; // reset_and_gap_ctrl
	localparam logic [3:0] SBR_OFS_PORT_CAP       = 4'h2; // port_capability_info
	localparam logic [3:0] SBR_OFS_SPEED_LATENCY  = 4'h3; // speed_latency_info
	localparam logic [3:0] SBR_OFS_LINK_POWER     = 4'h4; // link_power_ctrl
	localparam logic [3:0] SBR_OFS_INTERRUPT_CTRL = 4'h5; // interrupt_ctrl
	localparam logic [3:0] SBR_OFS_LEGACY_BRIDGE  = 4'h6; // legacy_speed_bridge
	localparam logic [3:0] SBR_OFS_PAGE_PORT      = 4'h7; // page_port_select
	localparam int         SBR_PAGED_BIT          = 3;    // address bit marking the paged half

	// event status and mask live in the paged half of the vendor page
	localparam logic [2:0] SBR_PAGE_EVENTS        = 3'h7;
	localparam logic [3:0] SBR_OFS_EVENT_STATUS   = 4'h8;
	localparam logic [3:0] SBR_OFS_EVENT_MASK     = 4'h9;

	// -----------------------------------------------------------------------
	// field positions (bit 7 is the first bit on the wire)
	// -----------------------------------------------------------------------
	localparam int SBR_NODE_ADDR_LSB = 2;
	localparam int SBR_ROOT_BIT      = 1;
	localparam int SBR_PWR_BIT       = 0;
	localparam int SBR_HOLDOFF_BIT   = 7;
	localparam int SBR_LONG_RST_BIT  = 6;
	localparam int SBR_GAP_LSB       = 0;
	localparam int SBR_EXT_LSB       = 5;
	localparam int SBR_PORTS_LSB     = 0;
	localparam int SBR_SPEED_LSB     = 5;
	localparam int SBR_DELAY_LSB     = 0;
	localparam int SBR_PAGE_LSB      = 5;
	localparam int SBR_PORT_LSB      = 0;

	// -----------------------------------------------------------------------
	// constant field values and reset values
	// -----------------------------------------------------------------------
	localparam logic [2:0] SBR_EXTENDED_VAL  = 3'h7;  // extended register set present
	localparam logic [4:0] SBR_NUM_PORTS_VAL = 5'h03; // three ports implemented
	localparam logic [2:0] SBR_SPEED_VAL     = 3'h7;  // legacy field, no longer used
	localparam logic [3:0] SBR_DELAY_VAL     = 4'h2;  // 144 ns + 20 ns per count
	localparam logic [5:0] SBR_GAP_RESET     = 6'h3F;
	localparam logic [5:0] SBR_NODE_RESET    = 6'h00;
	localparam logic [2:0] SBR_PAGE_RESET    = 3'h0;
	localparam logic [3:0] SBR_PORT_RESET    = 4'h0;

	// -----------------------------------------------------------------------
	// event bits of the status and mask registers
	// -----------------------------------------------------------------------
	localparam int         SBR_EVT_W         = 4;
	localparam int         SBR_EVT_BUS_RESET = 0;
	localparam int         SBR_EVT_SELF_ID   = 1;
	localparam int         SBR_EVT_ROOT      = 2;
	localparam int         SBR_EVT_PWR_LOST  = 3;
	localparam logic [3:0] SBR_EVT_RESET     = 4'h0;

	// -----------------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------------
	localparam int          SBR_CLK_PERIOD_NS  = 50;
	localparam int          SBR_LONG_RESET_NS  = 166000;
	localparam int          SBR_LONG_RESET_W   = 12;
	localparam logic [11:0] SBR_LONG_RESET_CYC =
		12'((SBR_LONG_RESET_NS + SBR_CLK_PERIOD_NS - 1) / SBR_CLK_PERIOD_NS);

	// long reset sequencing as seen by the register file
	typedef enum logic [1:0] {
		SBR_LR_IDLE = 2'b01,
		SBR_LR_RUN  = 2'b10
	} sbr_lr_e;

	// timer states
	typedef enum logic [1:0] {
		SBR_TMR_IDLE = 2'b01,
		SBR_TMR_RUN  = 2'b10
	} sbr_tmr_e;

endpackage : sbr_pkg

// ==== core/sbr_long_reset_timer.sv ====
// timer that holds the long bus reset for its full duration
module sbr_long_reset_timer
	import sbr_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      active,
	output logic      done
);

	typedef struct packed {
		sbr_tmr_e                    state;
		logic [SBR_LONG_RESET_W-1:0] cnt;
		logic                        active;
		logic                        done;
	} sbr_tmr_s;

	sbr_tmr_s s;
	sbr_tmr_s next_s;

	// count down the reset length; done pulses once at the end
	always_comb begin
		next_s      = s;
		next_s.done = 1'b0;
		case (s.state)
			SBR_TMR_IDLE: begin
				if (start) begin
					next_s.state  = SBR_TMR_RUN;
					next_s.cnt    = SBR_LONG_RESET_CYC - 12'h001;
					next_s.active = 1'b1;
				end
			end
			SBR_TMR_RUN: begin
				if (s.cnt == 12'h000) begin
					next_s.state  = SBR_TMR_IDLE;
					next_s.active = 1'b0;
					next_s.done   = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 12'h001;
				end
			end
			default: begin
				next_s.state  = SBR_TMR_IDLE;
				next_s.active = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '{state: SBR_TMR_IDLE, cnt: 12'h000, active: 1'b0, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign active = s.active;
	assign done   = s.done;

endmodule : sbr_long_reset_timer

// ==== core/sbr_phy_regs.sv ====
// base register file of the serial-bus cable phy, with event status and mask
// each race has one fixed winner,
// noted where it is settled,
// and outputs come from flops
module sbr_phy_regs
	import sbr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// phy core status
	input  wire logic       bus_reset_seen,
	// busy while rx or tx runs
	input  wire logic       link_busy,
	input  wire logic       self_id_done,
	input  wire logic [5:0] self_id_addr,
	input  wire logic       tree_id_root,
	// high while power is good
	input  wire logic       cable_power_sense,
	// configuration packet updates
	input  wire logic       cfg_gap_valid,
	input  wire logic [5:0] cfg_gap,
	input  wire logic       cfg_holdoff_valid,
	input  wire logic       cfg_holdoff,
	// controls toward the phy core
	output logic      [5:0] gap_count,
	output logic            root_holdoff,
	output logic            node_address_valid,
	output logic            long_bus_reset,
	output logic      [2:0] page_select,
	output logic      [3:0] port_select,
	// level interrupt
	output logic            irq
);

	// -----------------------------------------------------------------------
	// state
	// -----------------------------------------------------------------------
	typedef struct packed {
		// node identity fields
		logic [5:0]           node_bus_address;
		logic                 addr_valid;
		logic                 root;
		logic                 cable_power_flag;
		logic                 pwr_prev;

		// control fields
		logic                 root_holdoff;
		logic                 long_bus_reset_request;
		logic [5:0]           gap;
		logic                 gap_stale;     // one bus reset seen with no gap update

		// select fields
		logic [2:0]           page;
		logic [3:0]           port;

		// events, read data, sequencer
		logic [SBR_EVT_W-1:0] evt_status;
		logic [SBR_EVT_W-1:0] evt_mask;
		logic [7:0]           rdata;
		logic                 irq;
		sbr_lr_e              lr_state;
		logic                 lr_start;
	} sbr_regs_s;

	sbr_regs_s s;
	sbr_regs_s next_s;
	// one pass fills next_s

	// timer handshake
	logic tmr_active;
	logic tmr_done;

	// -----------------------------------------------------------------------
	// long bus reset timer
	// -----------------------------------------------------------------------
	// start pulses for one cycle
	// done ends the sequencer wait
	sbr_long_reset_timer u_timer (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (s.lr_start),
		.active  (tmr_active),
		.done    (tmr_done)
	);

	// -----------------------------------------------------------------------
	// decode helpers
	// -----------------------------------------------------------------------
	// decode and helpers
	logic                 bus_reset;   // any bus reset, seen or started here
	logic                 paged;
	logic                 events_page;
	logic                 wr_reset_gap;
	logic                 wr_page_port;
	logic                 wr_mask;
	logic                 rd_status;
	logic [SBR_EVT_W-1:0] evt_now;
	logic [7:0]           rd_value;

	// our own long reset counts as a bus reset at the moment it starts
	assign bus_reset    = bus_reset_seen | s.lr_start;

	// address decode
	assign paged        = reg_addr[SBR_PAGED_BIT];
	assign events_page  = (s.page == SBR_PAGE_EVENTS);
	assign wr_reset_gap = reg_wr && (reg_addr == SBR_OFS_RESET_GAP);
	assign wr_page_port = reg_wr && (reg_addr == SBR_OFS_PAGE_PORT);
	assign wr_mask      = reg_wr && events_page && (reg_addr == SBR_OFS_EVENT_MASK);
	assign rd_status    = reg_rd && events_page && (reg_addr == SBR_OFS_EVENT_STATUS);

	// events that set the sticky status bits this cycle
	always_comb begin
		evt_now                    = SBR_EVT_RESET;
		evt_now[SBR_EVT_BUS_RESET] = bus_reset;
		evt_now[SBR_EVT_SELF_ID]   = self_id_done;

		// root pulse masked by a bus reset
		evt_now[SBR_EVT_ROOT]      = tree_id_root & ~bus_reset;

		// power loss: falling edge only
		evt_now[SBR_EVT_PWR_LOST]  = s.pwr_prev & ~cable_power_sense;
	end

	// -----------------------------------------------------------------------
	// read multiplexer
	// -----------------------------------------------------------------------
	// base half is page independent, paged half holds only the event pair
	always_comb begin
		rd_value = 8'h00;
		if (!paged) begin
			case (reg_addr)
				// id, root and power flags
				SBR_OFS_NODE_IDENTITY: begin
					rd_value[SBR_NODE_ADDR_LSB +: 6] = s.node_bus_address;
					rd_value[SBR_ROOT_BIT]           = s.root;
					rd_value[SBR_PWR_BIT]            = s.cable_power_flag;
				end

				// holdoff, request, gap
				SBR_OFS_RESET_GAP: begin
					rd_value[SBR_HOLDOFF_BIT]  = s.root_holdoff;
					rd_value[SBR_LONG_RST_BIT] = s.long_bus_reset_request;
					rd_value[SBR_GAP_LSB +: 6] = s.gap;
				end

				// fixed capability constants
				SBR_OFS_PORT_CAP: begin
					rd_value[SBR_EXT_LSB +: 3]   = SBR_EXTENDED_VAL;
					rd_value[SBR_PORTS_LSB +: 5] = SBR_NUM_PORTS_VAL;
				end

				// legacy speed and latency
				SBR_OFS_SPEED_LATENCY: begin
					rd_value[SBR_SPEED_LSB +: 3] = SBR_SPEED_VAL;
					rd_value[SBR_DELAY_LSB +: 4] = SBR_DELAY_VAL;
				end

				// page high, port low
				SBR_OFS_PAGE_PORT: begin
					rd_value[SBR_PAGE_LSB +: 3] = s.page;
					rd_value[SBR_PORT_LSB +: 4] = s.port;
				end
				default: begin
					rd_value = 8'h00; // registers 4 to 6 not held here
				end
			endcase
		end else if (events_page) begin
			// only the event pair here
			case (reg_addr)
				SBR_OFS_EVENT_STATUS: rd_value[SBR_EVT_W-1:0] = s.evt_status;
				SBR_OFS_EVENT_MASK:   rd_value[SBR_EVT_W-1:0] = s.evt_mask;
				default:              rd_value = 8'h00;
			endcase
		end
	end

	// -----------------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------------
	always_comb begin
		next_s          = s;
		next_s.lr_start = 1'b0;

		// read data stand only in the cycle after the read strobe
		// so no stale value lingers
		next_s.rdata = reg_rd ? rd_value : 8'h00;

		// node address is invalid from a bus reset until self-id completes
		// self-id wins in one cycle
		if (bus_reset) begin
			next_s.addr_valid = 1'b0;
		end
		if (self_id_done) begin
			next_s.node_bus_address = self_id_addr;
			next_s.addr_valid       = 1'b1;
		end

		// root flag: cleared by every bus reset, set when tree-id makes us root
		// the clear wins over tree-id
		if (bus_reset) begin
			next_s.root = 1'b0;
		end else if (tree_id_root) begin
			next_s.root = 1'b1;
		end

		// cable power sense is sampled straight into the flag
		// prev feeds the loss event
		next_s.cable_power_flag = cable_power_sense;
		next_s.pwr_prev         = cable_power_sense;

		// root holdoff survives bus resets; config packets are the expected path
		// a packet wins over a write
		if (cfg_holdoff_valid) begin
			next_s.root_holdoff = cfg_holdoff;
		end else if (wr_reset_gap) begin
			next_s.root_holdoff = reg_wdata[SBR_HOLDOFF_BIT];
		end

		// long reset request: a bus reset clears it, a write in the same cycle wins
		// a request in a reset is kept
		if (bus_reset) begin
			next_s.long_bus_reset_request = 1'b0;
		end
		if (wr_reset_gap && reg_wdata[SBR_LONG_RST_BIT]) begin
			next_s.long_bus_reset_request = 1'b1;
		end

		// start the long reset only once the link is quiet
		// our start is a bus reset too
		case (s.lr_state)
			// request, quiet link, idle timer
			SBR_LR_IDLE: begin
				if (s.long_bus_reset_request && !link_busy && !tmr_active) begin
					next_s.lr_start = 1'b1;
					next_s.lr_state = SBR_LR_RUN;
				end
			end

			// block restarts until done
			SBR_LR_RUN: begin
				if (tmr_done) begin
					next_s.lr_state = SBR_LR_IDLE;
				end
			end
			default: begin
				next_s.lr_state = SBR_LR_IDLE;
			end
		endcase

		// gap: an update clears staleness; a second bare bus reset restores 3Fh
		// same-cycle update counts
		if (cfg_gap_valid) begin
			next_s.gap       = cfg_gap;
			next_s.gap_stale = 1'b0;
		end else if (wr_reset_gap) begin
			next_s.gap       = reg_wdata[SBR_GAP_LSB +: 6];
			next_s.gap_stale = 1'b0;
		end else if (bus_reset) begin
			// second bare reset in a row
			if (s.gap_stale) begin
				next_s.gap = SBR_GAP_RESET;
			end
			next_s.gap_stale = 1'b1;
		end

		// page and port selection
		// base fields ignore the page
		if (wr_page_port) begin
			next_s.page = reg_wdata[SBR_PAGE_LSB +: 3];
			next_s.port = reg_wdata[SBR_PORT_LSB +: 4];
		end

		// event mask, writable only through the events page
		// mask bits match status bits
		if (wr_mask) begin
			next_s.evt_mask = reg_wdata[SBR_EVT_W-1:0];
		end

		// sticky status: a read clears, a new event in that cycle survives it
		// no event lost to a read
		if (rd_status) begin
			next_s.evt_status = evt_now;
		end else begin
			next_s.evt_status = s.evt_status | evt_now;
		end

		// interrupt level follows the registered status and mask
		// from next values, so a flop
		next_s.irq = |(next_s.evt_status & next_s.evt_mask);
		// writes elsewhere fall through with no effect
	end

	// -----------------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------------
	// sync reset, constants only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s.node_bus_address       <= SBR_NODE_RESET;
			s.addr_valid             <= 1'b0;
			s.root                   <= 1'b0;
			s.cable_power_flag       <= 1'b0;
			s.pwr_prev               <= 1'b0;
			s.root_holdoff           <= 1'b0;
			s.long_bus_reset_request <= 1'b0;
			s.gap                    <= SBR_GAP_RESET;
			s.gap_stale              <= 1'b0;
			s.page                   <= SBR_PAGE_RESET;
			s.port                   <= SBR_PORT_RESET;
			s.evt_status             <= SBR_EVT_RESET;
			s.evt_mask               <= SBR_EVT_RESET;
			s.rdata                  <= 8'h00;
			s.irq                    <= 1'b0;
			s.lr_state               <= SBR_LR_IDLE;
			s.lr_start               <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// -----------------------------------------------------------------------
	// outputs, all straight from flip-flops
	// -----------------------------------------------------------------------
	// registered read data
	assign reg_rdata          = s.rdata;
	// controls to the phy core
	assign gap_count          = s.gap;
	assign root_holdoff       = s.root_holdoff;
	assign node_address_valid = s.addr_valid;
	// the timer owns this flop
	assign long_bus_reset     = tmr_active; // timer flop
	assign page_select        = s.page;
	assign port_select        = s.port;
	assign irq                = s.irq;

endmodule : sbr_phy_regs

// ==== sim/sbr_phy_regs_assertions.sv ====
// concurrent checks on the ports of the phy base register file
module sbr_phy_regs_assertions
	import sbr_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       bus_reset_seen,
	input wire logic       self_id_done,
	input wire logic       cable_power_sense,
	input wire logic       cfg_gap_valid,
	input wire logic       cfg_holdoff_valid,
	input wire logic [5:0] cfg_gap,
	input wire logic [5:0] gap_count,
	input wire logic       root_holdoff,
	input wire logic       node_address_valid,
	input wire logic       long_bus_reset,
	input wire logic [2:0] page_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ---------------------------------------------------------------------
	// helper logic
	// ---------------------------------------------------------------------
	logic        gap_upd;
	logic [1:0]  quiet_resets;
	logic [12:0] high_cycles;

	// a write or a config packet both count as a gap update
	assign gap_upd = cfg_gap_valid || (reg_wr && reg_addr == SBR_OFS_RESET_GAP);

	// bus resets since the last gap update; length of the long reset so far
	always_ff @(posedge clk) begin
		if (!reset_n || gap_upd) begin
			quiet_resets <= 2'h0;
		end else if (bus_reset_seen && quiet_resets != 2'h2) begin
			quiet_resets <= quiet_resets + 2'h1;
		end
		high_cycles <= (!reset_n || !long_bus_reset) ? 13'h0000 : high_cycles + 13'h0001;
	end

	sequence s_read(logic [3:0] a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_second_quiet_reset;
		bus_reset_seen && !gap_upd && quiet_resets == 2'h1;
	endsequence

	// ---------------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------------
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_port_cap_const: assert property (s_read(SBR_OFS_PORT_CAP) |=> reg_rdata == 8'hE3)
		else $error("port capability register wrong");
	a_speed_lat_const: assert property (s_read(SBR_OFS_SPEED_LATENCY) |=> reg_rdata == 8'hE2)
		else $error("speed latency register wrong");
	a_reserved_reads_zero: assert property (reg_rd && (reg_addr inside {4'h4, 4'h5, 4'h6}
		|| (reg_addr[3] && page_select inside {[3'h2:3'h6]})) |=> reg_rdata == 8'h00)
		else $error("reserved register read not zero");
	a_pwr_mirror: assert property (s_read(SBR_OFS_NODE_IDENTITY)
		|=> reg_rdata[SBR_PWR_BIT] == $past(cable_power_sense, 2))
		else $error("cable power flag does not follow sense");
	a_gap_reg_write: assert property (reg_wr && reg_addr == SBR_OFS_RESET_GAP && !cfg_gap_valid
		|=> {2'h0, gap_count} == ($past(reg_wdata) & 8'h3F))
		else $error("gap not taken from register write");
	a_gap_cfg_packet: assert property (cfg_gap_valid |=> gap_count == $past(cfg_gap))
		else $error("gap not taken from config packet");
	a_gap_two_resets: assert property (s_second_quiet_reset |=> gap_count == 6'h3F)
		else $error("gap not restored after two bus resets");
	a_long_reset_len: assert property ($fell(long_bus_reset) |-> high_cycles == 13'h0CF8)
		else $error("long bus reset length wrong");
	a_self_id_valid: assert property (self_id_done && !bus_reset_seen |=> node_address_valid)
		else $error("node address not valid after self id");
	a_bus_reset_inval: assert property (bus_reset_seen && !self_id_done |=> !node_address_valid)
		else $error("node address still valid after bus reset");
	a_holdoff_kept: assert property (bus_reset_seen && !cfg_holdoff_valid && !reg_wr
		|=> $stable(root_holdoff))
		else $error("root holdoff changed by bus reset");
endmodule : sbr_phy_regs_assertions

bind sbr_phy_regs sbr_phy_regs_assertions sbr_phy_regs_assertions_inst (
	.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_reset_seen,
	.self_id_done, .cable_power_sense, .cfg_gap_valid, .cfg_holdoff_valid, .cfg_gap,
	.gap_count, .root_holdoff, .node_address_valid, .long_bus_reset, .page_select
);

// ==== sim/sbr_link_model.sv ====
// link-layer controller model that reads and writes the phy registers
module sbr_link_model
	import sbr_pkg::*;
(
	input  wire logic       clk,
	output logic      [3:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// one-cycle write; released lines show inverted values, not stale ones
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	// one-cycle read; data taken only in the following cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd

	// long reset request keeps the other bits of the register as read
	task automatic long_reset_req(input logic [7:0] cur);
		wr(SBR_OFS_RESET_GAP, cur | (8'h01 << SBR_LONG_RST_BIT));
	endtask : long_reset_req
endmodule : sbr_link_model

// ==== sim/sbr_phy_regs_bench.sv ====
// self-checking bench of the phy base register file
module sbr_phy_regs_bench
	import sbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       bus_reset_seen = 1'b0;
	logic       link_busy = 1'b0;
	logic       self_id_done = 1'b0;
	logic [5:0] self_id_addr = 6'h00;
	logic       tree_id_root = 1'b0;
	logic       cable_power_sense = 1'b1;
	logic       cfg_gap_valid = 1'b0;
	logic [5:0] cfg_gap = 6'h00;
	logic       cfg_holdoff_valid = 1'b0;
	logic       cfg_holdoff = 1'b0;
	logic [5:0] gap_count;
	logic       root_holdoff;
	logic       node_address_valid;
	logic       long_bus_reset;
	logic [2:0] page_select;
	logic [3:0] port_select;
	logic       irq;
	int         checks = 0;
	int         num_errors = 0;
	logic [7:0] reset_map [16] = '{0: 8'h01, 1: 8'h3F, 2: 8'hE3, 3: 8'hE2, default: 8'h00};
	logic [3:0] ro_addr [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'hC};

	// 20 MHz clock
	always #25 clk = ~clk;

	sbr_phy_regs sbr_phy_regs_inst (
		.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_reset_seen,
		.link_busy, .self_id_done, .self_id_addr, .tree_id_root, .cable_power_sense,
		.cfg_gap_valid, .cfg_gap, .cfg_holdoff_valid, .cfg_holdoff, .gap_count, .root_holdoff,
		.node_address_valid, .long_bus_reset, .page_select, .port_select, .irq
	);
	sbr_link_model sbr_link_model_inst (
		.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
	);

	// ---------------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic bus_reset();
		@(posedge clk);
		bus_reset_seen <= 1'b1;
		@(posedge clk);
		bus_reset_seen <= 1'b0;
		#1;
	endtask : bus_reset

	// ---------------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------------
	initial begin
		logic [7:0] d;
		int n;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		// reset values of all sixteen places on page zero
		for (int a = 0; a < 16; a++) begin
			sbr_link_model_inst.rd(4'(a), d);
			chk("reset map", 16'(d), 16'(reset_map[a]));
		end
		// writes to read-only and reserved places leave them as they were
		foreach (ro_addr[i]) begin
			sbr_link_model_inst.wr(ro_addr[i], 8'hFF);
			sbr_link_model_inst.rd(ro_addr[i], d);
			chk("ro write", 16'(d), 16'(reset_map[ro_addr[i]]));
		end
		// gap by register write, by config packet, then two quiet bus resets
		sbr_link_model_inst.wr(SBR_OFS_RESET_GAP, 8'h05);
		sbr_link_model_inst.rd(SBR_OFS_RESET_GAP, d);
		chk("gap write", 16'(d), 16'h0005);
		chk("gap port", 16'(gap_count), 16'h0005);
		@(posedge clk);
		cfg_gap_valid <= 1'b1;
		cfg_gap       <= 6'h12;
		@(posedge clk);
		cfg_gap_valid <= 1'b0;
		bus_reset();
		sbr_link_model_inst.rd(SBR_OFS_RESET_GAP, d);
		chk("gap one reset", 16'(d), 16'h0012);
		bus_reset();
		chk("node valid", 16'(node_address_valid), 16'h0000);
		sbr_link_model_inst.rd(SBR_OFS_RESET_GAP, d);
		chk("gap two resets", 16'(d), 16'h003F);
		// self id and tree id, then a bus reset clears root
		@(posedge clk);
		self_id_done <= 1'b1;
		self_id_addr <= 6'h2A;
		tree_id_root <= 1'b1;
		@(posedge clk);
		self_id_done <= 1'b0;
		tree_id_root <= 1'b0;
		sbr_link_model_inst.rd(SBR_OFS_NODE_IDENTITY, d);
		chk("node reg", 16'(d), 16'h00AB);
		chk("node valid", 16'(node_address_valid), 16'h0001);
		bus_reset();
		sbr_link_model_inst.rd(SBR_OFS_NODE_IDENTITY, d);
		chk("root cleared", 16'(d & 8'h02), 16'h0000);
		// holdoff by config packet survives a bus reset
		@(posedge clk);
		cfg_holdoff_valid <= 1'b1;
		cfg_holdoff       <= 1'b1;
		@(posedge clk);
		cfg_holdoff_valid <= 1'b0;
		bus_reset();
		sbr_link_model_inst.rd(SBR_OFS_RESET_GAP, d);
		chk("holdoff kept", 16'(d), 16'h00BF);
		chk("holdoff port", 16'(root_holdoff), 16'h0001);
		// cable power drops
		@(posedge clk);
		cable_power_sense <= 1'b0;
		repeat (2) @(posedge clk);
		sbr_link_model_inst.rd(SBR_OFS_NODE_IDENTITY, d);
		chk("pwr flag", 16'(d & 8'h01), 16'h0000);
		// event page: mask, status, clear on read
		sbr_link_model_inst.wr(SBR_OFS_PAGE_PORT, 8'hE5);
		sbr_link_model_inst.rd(SBR_OFS_PAGE_PORT, d);
		chk("page reg", 16'(d), 16'h00E5);
		chk("page port", 16'({page_select, port_select}), 16'h0075);
		chk("irq masked", 16'(irq), 16'h0000);
		sbr_link_model_inst.wr(SBR_OFS_EVENT_MASK, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq raised", 16'(irq), 16'h0001);
		sbr_link_model_inst.rd(SBR_OFS_EVENT_STATUS, d);
		chk("status", 16'(d), 16'h000F);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 16'(irq), 16'h0000);
		sbr_link_model_inst.rd(SBR_OFS_EVENT_STATUS, d);
		chk("status empty", 16'(d), 16'h0000);
		// reserved page three; base fields do not depend on the page
		sbr_link_model_inst.wr(SBR_OFS_PAGE_PORT, 8'h60);
		sbr_link_model_inst.rd(SBR_OFS_EVENT_MASK, d);
		chk("page three", 16'(d), 16'h0000);
		sbr_link_model_inst.rd(SBR_OFS_PORT_CAP, d);
		chk("base on page", 16'(d), 16'h00E3);
		// long reset waits while the link is busy, then runs its full length
		@(posedge clk);
		link_busy <= 1'b1;
		sbr_link_model_inst.rd(SBR_OFS_RESET_GAP, d);
		sbr_link_model_inst.long_reset_req(d);
		repeat (20) @(posedge clk);
		#1 chk("long waits", 16'(long_bus_reset), 16'h0000);
		@(posedge clk);
		link_busy <= 1'b0;
		n = 0;
		while (long_bus_reset !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1 n++;
		end
		chk("long start", 16'(long_bus_reset), 16'h0001);
		n = 0;
		while (long_bus_reset === 1'b1 && n < 4000) begin
			@(posedge clk);
			#1 n++;
		end
		chk("long length", 16'(n), 16'h0CF8);
		sbr_link_model_inst.rd(SBR_OFS_RESET_GAP, d);
		chk("long req clear", 16'(d & 8'h40), 16'h0000);
		end_of_test();
	end
endmodule : sbr_phy_regs_bench
